// ==== design/tpw_pkg.sv ====
/*
  Constants and types shared by the tuner PLL write port.
  Assumes nothing of its surroundings; holds definitions only.
*/
package tpw_pkg;
  // ===========================================================
  // Timing
  // ===========================================================
  localparam int SYS_CLK_MHZ = 25;
  localparam int GLITCH_NS = 50;
  localparam int LINK_PERIOD_NS = 12;
  // Longest time rounds down, never below one cycle.
  localparam int GLITCH_CYC_RAW = GLITCH_NS / LINK_PERIOD_NS;
  localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
  localparam int GLITCH_CW = 4;

  // ===========================================================
  // Address byte
  // ===========================================================
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam int ADDR_FIXED_LSB = 3;
  localparam int ADDR_SEL_HI = 2;
  localparam int ADDR_SEL_LO = 1;
  localparam int ADDR_RW_BIT = 0;

  // ===========================================================
  // Data byte fields
  // ===========================================================
  localparam int HDR_BIT = 7;
  localparam int BG_HI_BIT = 6;
  localparam int BG_LO_BIT = 5;
  localparam int ADJ_MODE_BIT = 2;
  localparam int TEST_SEL_MSB_BIT = 2;
  localparam int PORT_OUT_BIT = 0;
  localparam int PRESCALER_BIT = 4;
  localparam int CP_HI_BIT = 6;
  localparam int CP_LO_BIT = 5;
  localparam int BAND_MSB = 7;
  localparam int BYTE_MSB = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Register slot indices inside the shadow array.
  localparam logic [1:0] SLOT_DIVH = 2'h0;
  localparam logic [1:0] SLOT_DIVL = 2'h1;
  localparam logic [1:0] SLOT_CTRL = 2'h2;
  localparam logic [1:0] SLOT_BAND = 2'h3;
  localparam logic [3:0] ALL_SLOTS = 4'hF;
  localparam logic [3:0] NO_SLOTS = 4'h0;

  // Position in the byte sequence of one transfer.
  typedef enum logic [2:0] {
    TPW_SEQ_ADDR,
    TPW_SEQ_FIRST,
    TPW_SEQ_DIVL_A,
    TPW_SEQ_BAND_A,
    TPW_SEQ_CTRL_B,
    TPW_SEQ_DIVH_B,
    TPW_SEQ_DIVL_B,
    TPW_SEQ_DONE
  } tpw_seq_t;
endpackage : tpw_pkg

// ==== design/tpw_sync_filt.sv ====
/*
  Three-stage synchroniser with a spike filter for one serial pin.
  Assumes the input is asynchronous to clk_in.
*/
`timescale 1ns/1ps
module tpw_sync_filt #(
  parameter int FILT_CYC = tpw_pkg::GLITCH_CYC
) (
  input wire logic clk_in,     // Sampling clock.
  input wire logic rst_in,     // Asynchronous reset, active high.
  input wire logic ce_in,      // Clock enable.
  input wire logic pin_in,     // Raw pin level.
  output logic level_out       // Filtered level.
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic [tpw_pkg::GLITCH_CW-1:0] cnt_r;
  logic [tpw_pkg::GLITCH_CW-1:0] cnt_nxt;
  logic level_nxt;

  // ===========================================================
  // Filter
  // ===========================================================
  // A new level must persist past the spike width before it is taken.
  always_comb begin
    sync_nxt = {sync_r[1:0], pin_in};
    cnt_nxt = cnt_r;
    level_nxt = level_out;
    if (sync_r[2] == sync_r[1] && sync_r[2] != level_out) begin
      if (cnt_r >= tpw_pkg::GLITCH_CW'(FILT_CYC)) begin
        level_nxt = sync_r[2];
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end else begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_r <= 3'h7;
      cnt_r <= '0;
      level_out <= 1'b1;
    end else if (ce_in) begin
      sync_r <= sync_nxt;
      cnt_r <= cnt_nxt;
      level_out <= level_nxt;
    end
  end
endmodule : tpw_sync_filt

// ==== design/tpw_level_cdc.sv ====
/*
  Two-flop level crossing plus toggle-event crossing into clk_in.
  Assumes the source toggle changes at most once per several clk_in edges.
*/
`timescale 1ns/1ps
module tpw_level_cdc #(
  parameter int W = 32
) (
  input wire logic clk_in,          // Destination clock.
  input wire logic rst_in,          // Asynchronous reset, active high.
  input wire logic ce_in,           // Clock enable.
  input wire logic toggle_in,       // Event toggle from link domain.
  input wire logic [W-1:0] data_in, // Word held stable around toggle.
  output logic pulse_out,           // One-cycle event pulse.
  output logic [W-1:0] data_out     // Captured word.
);
  logic [2:0] tog_r;
  logic [2:0] tog_nxt;
  logic pulse_nxt;
  logic [W-1:0] data_nxt;

  // ===========================================================
  // Handshake by toggle
  // ===========================================================
  // Data is sampled only after the toggle has settled two stages deep.
  always_comb begin
    tog_nxt = {tog_r[1:0], toggle_in};
    pulse_nxt = tog_r[2] ^ tog_r[1];
    data_nxt = pulse_nxt ? data_in : data_out;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_r <= 3'h0;
      pulse_out <= 1'b0;
      data_out <= '0;
    end else if (ce_in) begin
      tog_r <= tog_nxt;
      pulse_out <= pulse_nxt;
      data_out <= data_nxt;
    end
  end
endmodule : tpw_level_cdc

// ==== design/tpw_write_port.sv ====
/*
  Serial write port of the tuner PLL synthesiser: receives the address
  byte and up to four data bytes, steers them into shadow registers and
  commits them to the active fields.
  Assumes link_clk_in is a free-running oversampling clock; serial pins
  are asynchronous to it. Active fields live on clk_in.
*/
// Functional notes
// - Every byte, address and data, is shifted most significant bit first.
// - Full order: address, divider high, divider low, control, band.
// - Alternative full order: address, control, band, divider high, low.
// - Address, both divider bytes, control, then stop or start commits.
// - Address, control, band, divider high, then stop or start commits.
// - Address and both divider bytes, then stop or start commits.
// - Address, control and band, then stop or start commits.
// - Address and divider high only, then stop or start commits.
// - Spikes of 50 ns or less on clock and data are ignored.
// - Two divider-high bits set the baseband amplifier gain.
// - A control-byte bit enables oscillator and filter adjust mode.
// - Top bit of first data byte: 0 is divider high, 1 control.
// - Partial writes commit at stop or start; full writes at once.
// - Bytes not written keep their previous values.
`timescale 1ns/1ps
module tpw_write_port #(
  parameter logic [1:0] ADDR_SEL = 2'h0
) (
  input wire logic clk_in,            // System clock, 25 MHz.
  input wire logic rst_in,            // Asynchronous reset, active high.
  input wire logic ce_in,             // Clock enable for all state.
  input wire logic link_clk_in,       // Link sampling clock.
  input wire logic scl_in,            // Serial clock pin.
  input wire logic sda_in,            // Serial data pin level.
  output logic sda_out,               // Serial data drive value.
  output logic sda_oe_out,            // Serial data drive enable.
  output logic [7:0] divider_high_gain_out,   // Active byte.
  output logic [7:0] divider_low_swallow_out, // Active byte.
  output logic [7:0] pump_filter_control_out, // Active byte.
  output logic [7:0] band_select_control_out, // Active byte.
  output logic [1:0] bb_gain_out,     // Baseband gain setting.
  output logic vco_lpf_adjust_mode_out, // Adjust mode enable.
  output logic commit_out             // Pulse when fields update.
);
  logic scl_f;
  logic sda_f;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_d_nxt;
  logic sda_d_nxt;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic active_r;
  logic active_nxt;
  logic ack_r;
  logic ack_nxt;
  logic sel_r;
  logic sel_nxt;
  logic byte_done_r;
  logic byte_done_nxt;
  logic slot_r;
  logic slot_nxt;
  tpw_pkg::tpw_seq_t seq_r;
  tpw_pkg::tpw_seq_t seq_nxt;
  logic [7:0] shadow_r [4];
  logic [7:0] shadow_nxt [4];
  logic [3:0] wmask_r;
  logic [3:0] wmask_nxt;
  logic [3:0] cmask_r;
  logic [3:0] cmask_nxt;
  logic [31:0] cword_r;
  logic [31:0] cword_nxt;
  logic ctog_r;
  logic ctog_nxt;
  logic do_commit;

  logic cpulse;
  logic [35:0] cdata;
  logic [7:0] act_r [4];
  logic [7:0] act_nxt [4];
  logic [7:0] rx_byte;

  function automatic logic [7:0] slot_mux(input logic [35:0] w,
                                          input logic [1:0] s);
    slot_mux = w[8*s +: 8];
  endfunction : slot_mux

  // ===========================================================
  // Pin conditioning
  // ===========================================================
  tpw_sync_filt u_scl (
    .clk_in(link_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(scl_in),
    .level_out(scl_f)
  );

  tpw_sync_filt u_sda (
    .clk_in(link_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(sda_in),
    .level_out(sda_f)
  );

  assign start_ev = scl_f && scl_d_r && sda_d_r && !sda_f;
  assign stop_ev = scl_f && scl_d_r && !sda_d_r && sda_f;
  assign scl_rise = scl_f && !scl_d_r;
  assign scl_fall = !scl_f && scl_d_r;
  assign rx_byte = {shift_r[6:0], sda_f};
  assign do_commit = active_r && (start_ev || stop_ev)
                     && wmask_r != tpw_pkg::NO_SLOTS;

  // ===========================================================
  // Link-side receiver
  // ===========================================================
  always_comb begin
    scl_d_nxt = scl_f;
    sda_d_nxt = sda_f;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    active_nxt = active_r;
    ack_nxt = ack_r;
    sel_nxt = sel_r;
    byte_done_nxt = byte_done_r;
    slot_nxt = slot_r;
    seq_nxt = seq_r;
    shadow_nxt = shadow_r;
    wmask_nxt = wmask_r;
    cmask_nxt = cmask_r;
    cword_nxt = cword_r;
    ctog_nxt = ctog_r;
    if (start_ev || stop_ev) begin
      if (do_commit) begin
        cmask_nxt = wmask_r;
        cword_nxt = {shadow_r[3], shadow_r[2], shadow_r[1], shadow_r[0]};
        ctog_nxt = !ctog_r;
      end
      active_nxt = start_ev;
      seq_nxt = tpw_pkg::TPW_SEQ_ADDR;
      bit_nxt = '0;
      ack_nxt = 1'b0;
      slot_nxt = 1'b0;
      sel_nxt = 1'b0;
      byte_done_nxt = 1'b0;
      wmask_nxt = tpw_pkg::NO_SLOTS;
    end else if (active_r && scl_rise && !slot_r) begin
      shift_nxt = rx_byte;
      bit_nxt = bit_r + 1'b1;
      if (bit_r == tpw_pkg::BIT_LAST) begin
        byte_done_nxt = 1'b1;
      end
    end else if (active_r && scl_fall && slot_r) begin
      ack_nxt = 1'b0;
      slot_nxt = 1'b0;
    end else if (active_r && scl_fall && byte_done_r) begin
      ack_nxt = 1'b1;
      slot_nxt = 1'b1;
      byte_done_nxt = 1'b0;
      case (seq_r)
        tpw_pkg::TPW_SEQ_ADDR: begin
          if (shift_r[7:tpw_pkg::ADDR_FIXED_LSB] == tpw_pkg::ADDR_FIXED
              && shift_r[tpw_pkg::ADDR_SEL_HI:tpw_pkg::ADDR_SEL_LO]
                 == ADDR_SEL
              && !shift_r[tpw_pkg::ADDR_RW_BIT]) begin
            seq_nxt = tpw_pkg::TPW_SEQ_FIRST;
          end else begin
            ack_nxt = 1'b0;
            active_nxt = 1'b0;
          end
        end
        default: ;
      endcase
      if (seq_r != tpw_pkg::TPW_SEQ_ADDR) begin
        if (seq_r == tpw_pkg::TPW_SEQ_DONE) begin
          ack_nxt = 1'b0;
        end
        case (seq_r)
          tpw_pkg::TPW_SEQ_FIRST: begin
            if (shift_r[tpw_pkg::HDR_BIT]) begin
              shadow_nxt[tpw_pkg::SLOT_CTRL] = shift_r;
              wmask_nxt[tpw_pkg::SLOT_CTRL] = 1'b1;
              seq_nxt = tpw_pkg::TPW_SEQ_BAND_A;
            end else begin
              shadow_nxt[tpw_pkg::SLOT_DIVH] = shift_r;
              wmask_nxt[tpw_pkg::SLOT_DIVH] = 1'b1;
              seq_nxt = tpw_pkg::TPW_SEQ_DIVL_A;
            end
          end
          tpw_pkg::TPW_SEQ_DIVL_A: begin
            shadow_nxt[tpw_pkg::SLOT_DIVL] = shift_r;
            wmask_nxt[tpw_pkg::SLOT_DIVL] = 1'b1;
            seq_nxt = tpw_pkg::TPW_SEQ_CTRL_B;
          end
          tpw_pkg::TPW_SEQ_CTRL_B: begin
            if (!sel_r) begin
              shadow_nxt[tpw_pkg::SLOT_CTRL] = shift_r;
              wmask_nxt[tpw_pkg::SLOT_CTRL] = 1'b1;
              seq_nxt = tpw_pkg::TPW_SEQ_BAND_A;
              sel_nxt = 1'b1;
            end else begin
              seq_nxt = tpw_pkg::TPW_SEQ_DONE;
            end
          end
          tpw_pkg::TPW_SEQ_BAND_A: begin
            shadow_nxt[tpw_pkg::SLOT_BAND] = shift_r;
            wmask_nxt[tpw_pkg::SLOT_BAND] = 1'b1;
            seq_nxt = sel_r ? tpw_pkg::TPW_SEQ_DONE
                            : tpw_pkg::TPW_SEQ_DIVH_B;
          end
          tpw_pkg::TPW_SEQ_DIVH_B: begin
            shadow_nxt[tpw_pkg::SLOT_DIVH] = shift_r;
            wmask_nxt[tpw_pkg::SLOT_DIVH] = 1'b1;
            seq_nxt = tpw_pkg::TPW_SEQ_DIVL_B;
          end
          tpw_pkg::TPW_SEQ_DIVL_B: begin
            shadow_nxt[tpw_pkg::SLOT_DIVL] = shift_r;
            wmask_nxt[tpw_pkg::SLOT_DIVL] = 1'b1;
            seq_nxt = tpw_pkg::TPW_SEQ_DONE;
          end
          default: begin
            seq_nxt = tpw_pkg::TPW_SEQ_DONE;
          end
        endcase
        // A full four-byte write takes effect without a terminator.
        if ((wmask_nxt == tpw_pkg::ALL_SLOTS)
            && (seq_nxt == tpw_pkg::TPW_SEQ_DONE)
            && (seq_r != tpw_pkg::TPW_SEQ_DONE)) begin
          cmask_nxt = tpw_pkg::ALL_SLOTS;
          cword_nxt = {shadow_nxt[3], shadow_nxt[2], shadow_nxt[1],
                       shadow_nxt[0]};
          ctog_nxt = !ctog_r;
          wmask_nxt = tpw_pkg::NO_SLOTS;
        end
      end
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      shift_r <= '0;
      bit_r <= '0;
      active_r <= 1'b0;
      ack_r <= 1'b0;
      sel_r <= 1'b0;
      byte_done_r <= 1'b0;
      slot_r <= 1'b0;
      seq_r <= tpw_pkg::TPW_SEQ_ADDR;
      for (int i = 0; i < 4; i++) begin
        shadow_r[i] <= '0;
      end
      wmask_r <= '0;
      cmask_r <= '0;
      cword_r <= '0;
      ctog_r <= 1'b0;
    end else if (ce_in) begin
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      active_r <= active_nxt;
      ack_r <= ack_nxt;
      sel_r <= sel_nxt;
      byte_done_r <= byte_done_nxt;
      slot_r <= slot_nxt;
      seq_r <= seq_nxt;
      shadow_r <= shadow_nxt;
      wmask_r <= wmask_nxt;
      cmask_r <= cmask_nxt;
      cword_r <= cword_nxt;
      ctog_r <= ctog_nxt;
    end
  end

  // The acknowledge pulls the open-drain line low; drive value is 0.
  assign sda_out = 1'b0;
  assign sda_oe_out = ack_r;

  // ===========================================================
  // Commit into the system domain
  // ===========================================================
  tpw_level_cdc #(
    .W(36)
  ) u_cdc (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .toggle_in(ctog_r),
    .data_in({cmask_r, cword_r}),
    .pulse_out(cpulse),
    .data_out(cdata)
  );

  always_comb begin
    act_nxt = act_r;
    if (cpulse) begin
      for (int i = 0; i < 4; i++) begin
        if (cdata[32 + i]) begin
          act_nxt[i] = slot_mux(cdata, 2'(i));
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        act_r[i] <= '0;
      end
      commit_out <= 1'b0;
    end else if (ce_in) begin
      act_r <= act_nxt;
      commit_out <= cpulse;
    end
  end

  assign divider_high_gain_out = act_r[tpw_pkg::SLOT_DIVH];
  assign divider_low_swallow_out = act_r[tpw_pkg::SLOT_DIVL];
  assign pump_filter_control_out = act_r[tpw_pkg::SLOT_CTRL];
  assign band_select_control_out = act_r[tpw_pkg::SLOT_BAND];
  assign bb_gain_out = {act_r[tpw_pkg::SLOT_DIVH][tpw_pkg::BG_HI_BIT],
                        act_r[tpw_pkg::SLOT_DIVH][tpw_pkg::BG_LO_BIT]};
  assign vco_lpf_adjust_mode_out =
    act_r[tpw_pkg::SLOT_CTRL][tpw_pkg::ADJ_MODE_BIT];
endmodule : tpw_write_port

// ==== verif/tpw_write_port_checker.sv ====
/*
  Concurrent checks on the ports of the tuner PLL write port.
  Assumes it is bound to tpw_write_port; reset is active high.
*/
`timescale 1ns/1ps
module tpw_write_port_checker (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Reset, active high.
  input wire logic link_clk_in, // Link clock.
  input wire logic scl_in, // Serial clock pin.
  input wire logic sda_out, // Data drive value.
  input wire logic sda_oe_out, // Data drive enable.
  input wire logic [7:0] divider_high_gain_out, // Active byte.
  input wire logic [7:0] divider_low_swallow_out, // Active byte.
  input wire logic [7:0] pump_filter_control_out, // Active byte.
  input wire logic [7:0] band_select_control_out, // Active byte.
  input wire logic [1:0] bb_gain_out, // Gain field.
  input wire logic vco_lpf_adjust_mode_out, // Adjust mode.
  input wire logic commit_out // Commit pulse.
);
  // ==========================================================
  // Sequences
  // ==========================================================
  // An acknowledge lasts about one bit time, never much longer.
  sequence ack_end_s;
    ##[1:250] !sda_oe_out;
  endsequence
  sequence ack_start_s;
    $rose(sda_oe_out);
  endsequence

  // ==========================================================
  // Assertions
  // ==========================================================
  gain_map_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    bb_gain_out == divider_high_gain_out[6:5])
    else $error("gain field differs from divider byte");
  adjust_map_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    vco_lpf_adjust_mode_out == pump_filter_control_out[2])
    else $error("adjust mode differs from control byte");
  bytes_hold_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed({divider_high_gain_out, divider_low_swallow_out,
      pump_filter_control_out, band_select_control_out})
    |-> commit_out || $past(commit_out))
    else $error("active bytes changed without a commit");
  commit_pulse_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    commit_out |=> !commit_out)
    else $error("commit pulse longer than one cycle");
  reset_clear_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $fell(rst_in) |-> !commit_out && divider_high_gain_out == 8'h00)
    else $error("outputs not clear after reset");
  ack_scl_low_a: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data drive changed while clock high");
  ack_release_a: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    ack_start_s |-> ack_end_s)
    else $error("acknowledge held too long");
  drive_low_a: assert property (
    @(posedge link_clk_in) disable iff (rst_in)
    sda_oe_out |-> sda_out == 1'b0)
    else $error("data line driven high");
endmodule : tpw_write_port_checker

// ==== verif/tpw_bus_master.sv ====
/*
  Behavioural serial bus master driving the write port's pins.
  Assumes the bench builds an open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
module tpw_bus_master #(
  parameter int Q = 300
) (
  input wire logic sda_in, // Resolved data line.
  output logic scl_out, // Serial clock, idle high.
  output logic sda_low_out // High pulls data low.
);
  logic spike_en;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    spike_en = 1'b0;
  end

  // ==========================================================
  // Framing
  // ==========================================================
  task automatic start();
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b0;
    #(4*Q);
  endtask : stop

  // Spikes of 40 ns stay inside the filter's limit, so the port
  // must neither clock a bit nor see a start or stop from them.
  task automatic put_bit(input logic b);
    sda_low_out = ~b;
    if (spike_en) begin
      #(Q-100) scl_out = 1'b1;
      #40 scl_out = 1'b0;
      #60;
    end else begin
      #Q;
    end
    scl_out = 1'b1;
    if (spike_en && b) begin
      #Q sda_low_out = 1'b1;
      #40 sda_low_out = 1'b0;
      #(Q-40);
    end else begin
      #(2*Q);
    end
    scl_out = 1'b0;
    #Q;
  endtask : put_bit

  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q ack = ~sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask : send
endmodule : tpw_bus_master

// ==== verif/tpw_write_port_test.sv ====
/*
  Self-checking bench for the tuner PLL write port.
  Assumes the design, checker and bus master are compiled first.
*/
`timescale 1ns/1ps
module tpw_write_port_test;
  localparam logic [1:0] SEL = 2'h2;
  localparam logic [7:0] ADR = {tpw_pkg::ADDR_FIXED, SEL, 1'b0};
  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_in = 1'b1;
  logic sda_out, sda_oe_out, commit_out, adj, scl, sda_low, sda_line;
  logic [7:0] divh, divl, ctrl, band;
  logic [1:0] gain;
  logic [7:0] exp_b [4];
  int num_errors = 0;
  int num_checks = 0;
  int commits = 0;

  always #20 clk_in = ~clk_in;
  initial begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  // Pull-up: the line is low while either party drives it.
  assign sda_line = ~(sda_low | (sda_oe_out & ~sda_out));
  always @(posedge clk_in) if (commit_out === 1'b1) commits++;

  tpw_write_port #(.ADDR_SEL(SEL)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .divider_high_gain_out(divh), .divider_low_swallow_out(divl),
    .pump_filter_control_out(ctrl), .band_select_control_out(band),
    .bb_gain_out(gain), .vco_lpf_adjust_mode_out(adj),
    .commit_out(commit_out));
  tpw_bus_master mst (.sda_in(sda_line), .scl_out(scl),
    .sda_low_out(sda_low));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // One transfer; term 0 none, 1 stop, 2 repeated start.
  task automatic go(input logic [7:0] adr, input logic [39:0] v,
    input int n, input int term, input logic ok);
    logic a;
    logic [7:0] b;
    logic [7:0] nxt [4];
    int c0;
    nxt = exp_b;
    mst.start();
    c0 = commits;
    for (int k = 0; k < n; k++) begin
      b = k ? v[47-8*k -: 8] : adr;
      mst.send(b, a);
      chk("ack", {7'h0, a}, {7'h0, ok && k < 5});
      if (ok && k > 0 && k < 5) begin
        nxt[v[39] ? (k + 1) % 4 : k - 1] = b;
      end
    end
    if (term != 0) begin
      repeat (20) @(posedge clk_in);
      chk("early commit", 8'(commits - c0), 8'h00);
      if (term == 1) mst.stop();
      else mst.start();
    end
    for (int i = 0; i < 60 && commits == c0; i++) @(posedge clk_in);
    repeat (10) @(posedge clk_in);
    chk("commits", 8'(commits - c0), {7'h0, ok});
    exp_b = nxt;
    chk("divider high", divh, exp_b[0]);
    chk("divider low", divl, exp_b[1]);
    chk("control", ctrl, exp_b[2]);
    chk("band", band, exp_b[3]);
    chk("gain", {6'h0, gain}, {6'h0, exp_b[0][6:5]});
    chk("adjust", {7'h0, adj}, {7'h0, exp_b[2][2]});
  endtask : go

  // ==========================================================
  // Sequence of tests
  // ==========================================================
  // Control bytes E4 and C4 set the test select bit; C0 and E0 keep it at zero.
  initial begin
    exp_b = '{default: 8'h00};
    repeat (5) @(posedge clk_in);
    #2 rst_in = 1'b0;
    repeat (10) @(posedge clk_in);
    go(ADR, 40'h5A_3C_E4_A9_11, 6, 0, 1'b1);
    mst.spike_en = 1'b1;
    go(ADR, 40'hC0_21_12_F8_00, 5, 0, 1'b1);
    mst.spike_en = 1'b0;
    go(ADR, 40'h60_77_A0_00_00, 4, 1, 1'b1);
    go(ADR, 40'hE0_4C_3F_00_00, 4, 1, 1'b1);
    go(ADR, 40'h7E_81_00_00_00, 3, 2, 1'b1);
    go(ADR, 40'hC4_55_00_00_00, 3, 1, 1'b1);
    go(ADR, 40'h20_00_00_00_00, 2, 1, 1'b1);
    go(ADR ^ 8'h06, 40'h00_00_00_00_00, 2, 1, 1'b0);
    conclude();
  end

  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
endmodule : tpw_write_port_test

bind tpw_write_port tpw_write_port_checker u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .divider_high_gain_out(divider_high_gain_out),
  .divider_low_swallow_out(divider_low_swallow_out),
  .pump_filter_control_out(pump_filter_control_out),
  .band_select_control_out(band_select_control_out),
  .bb_gain_out(bb_gain_out),
  .vco_lpf_adjust_mode_out(vco_lpf_adjust_mode_out),
  .commit_out(commit_out));
